// [src/exec_params.svh]
// Constants of the data-transfer and control execution unit.
// Assumes 32 general registers, pointer pairs in the top six.
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

// ==========================================
// Register file layout
`define REG_LOW_WORD   5'h00
`define BASE_LOW       5'h00
`define BASE_X         5'h1A
`define BASE_Y         5'h1C
`define BASE_Z         5'h1E
`define REG_RESET      8'h00

// ==========================================
// Address arithmetic and reset values
`define PTR_STEP       16'h0001
`define WORD_RESET     16'h0000
`define BYTE_RESET     8'h00
`define SP_RESET       16'h00FF

`endif

// [src/exec_pkg.sv]
// Types shared by the execution unit and its register file.
// Assumes the decoder upstream delivers one op_t per instruction.
package exec_pkg;
	typedef enum logic [4:0] {
		OP_IDLE_INSTR    = 5'h00,
		OP_LOAD_DISP     = 5'h01,
		OP_LOAD_DIRECT   = 5'h02,
		OP_STORE_IND     = 5'h03,
		OP_STORE_POSTINC = 5'h04,
		OP_STORE_PREDEC  = 5'h05,
		OP_STORE_DISP    = 5'h06,
		OP_STORE_DIRECT  = 5'h07,
		OP_PM_READ_LOW   = 5'h08,
		OP_PM_READ       = 5'h09,
		OP_PM_READ_INC   = 5'h0A,
		OP_PM_WRITE      = 5'h0B,
		OP_PUSH          = 5'h0C,
		OP_POP           = 5'h0D,
		OP_PORT_IN       = 5'h0E,
		OP_PORT_OUT      = 5'h0F,
		OP_SLEEP         = 5'h10,
		OP_WATCHDOG      = 5'h11,
		OP_BREAK         = 5'h12
	} op_t;

	typedef enum logic [1:0] {
		PTR_LOW = 2'b00,
		PTR_X   = 2'b01,
		PTR_Y   = 2'b10,
		PTR_Z   = 2'b11
	} ptr_t;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_MEM  = 3'b001,
		SEQ_PM1  = 3'b010,
		SEQ_PM2  = 3'b011,
		SEQ_PMW  = 3'b100,
		SEQ_BRK  = 3'b101
	} state_t;
endpackage : exec_pkg

// [src/regfile_if.sv]
// Connection between the execution unit and the register file.
// Reads are combinational from the register array.
interface regfile_if;
	import exec_pkg::*;
	logic [4:0]  rd_idx;
	logic [7:0]  rd_data;
	ptr_t        pair_sel;
	logic [15:0] pair_data;
	logic [15:0] low_word;
	logic        wr_en;
	logic [4:0]  wr_idx;
	logic [7:0]  wr_data;
	logic        pw_en;
	ptr_t        pw_sel;
	logic [15:0] pw_data;

	modport ctrl (output rd_idx, pair_sel, wr_en, wr_idx, wr_data, pw_en, pw_sel, pw_data,
		input rd_data, pair_data, low_word);
	modport rf (input rd_idx, pair_sel, wr_en, wr_idx, wr_data, pw_en, pw_sel, pw_data,
		output rd_data, pair_data, low_word);
endinterface : regfile_if

// [src/gp_regfile.sv]
// General register file: 32 bytes, pointer pairs read and written as words.
// Assumes byte and word writes never target the same pair in one cycle.
`include "exec_params.svh"

module gp_regfile
	import exec_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic nrst,
	// Access from the execution unit
	regfile_if.rf     bus
);
	logic [7:0] regs_r [32];
	logic [4:0] rbase;
	logic [4:0] wbase;

	assign rbase = (bus.pair_sel == PTR_X) ? `BASE_X :
		(bus.pair_sel == PTR_Y) ? `BASE_Y :
		(bus.pair_sel == PTR_Z) ? `BASE_Z : `BASE_LOW;
	assign wbase = (bus.pw_sel == PTR_X) ? `BASE_X :
		(bus.pw_sel == PTR_Y) ? `BASE_Y :
		(bus.pw_sel == PTR_Z) ? `BASE_Z : `BASE_LOW;

	assign bus.rd_data   = regs_r[bus.rd_idx];
	assign bus.pair_data = {regs_r[rbase + 5'h01], regs_r[rbase]};
	assign bus.low_word  = {regs_r[`BASE_LOW + 5'h01], regs_r[`BASE_LOW]};

	// ==========================================
	// Storage; the word write lands after the byte write
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 32; i++) regs_r[i] <= `REG_RESET;
		end else begin
			if (bus.wr_en) regs_r[bus.wr_idx] <= bus.wr_data;
			if (bus.pw_en) begin
				regs_r[wbase]         <= bus.pw_data[7:0];
				regs_r[wbase + 5'h01] <= bus.pw_data[15:8];
			end
		end
	end
endmodule : gp_regfile

// [src/xfer_ctrl_exec.sv]
// Execution of data-transfer and processor-control instructions.
// Assumes data memory answers reads in the same cycle and program
// memory one cycle after its read strobe. Status flags are never written.
`include "exec_params.svh"

module xfer_ctrl_exec
	import exec_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// Decoded instruction
	input  wire logic        instr_valid,
	output wire logic        instr_ready,
	input  wire op_t         instr_op,
	input  wire logic [4:0]  instr_rd,
	input  wire logic [4:0]  instr_rr,
	input  wire ptr_t        instr_ptr,
	input  wire logic [5:0]  instr_disp,
	input  wire logic [15:0] instr_addr,
	input  wire logic [5:0]  instr_port,
	// Data memory and stack
	output wire logic [15:0] dmem_addr,
	output wire logic [7:0]  dmem_wdata,
	output wire logic        dmem_we,
	output wire logic        dmem_re,
	input  wire logic [7:0]  dmem_rdata,
	output wire logic [15:0] stack_ptr,
	// Program memory
	output wire logic [15:0] pmem_addr,
	output wire logic        pmem_re,
	input  wire logic [7:0]  pmem_rdata,
	output wire logic        pmem_we,
	output wire logic [15:0] pmem_wdata,
	input  wire logic        pmem_done,
	// I/O space
	output wire logic [5:0]  io_addr,
	output wire logic [7:0]  io_wdata,
	output wire logic        io_we,
	output wire logic        io_re,
	input  wire logic [7:0]  io_rdata,
	// Control pulses
	output wire logic        sleep_req,
	output wire logic        wdt_restart,
	output wire logic        break_req,
	input  wire logic        debug_resume
);
	regfile_if rf ();
	gp_regfile u_rf (.clk_sys(clk_sys), .nrst(nrst), .bus(rf.rf));

	state_t      state_r, state_nxt;
	logic [4:0]  rd_r;
	logic        ptr_upd_r;
	ptr_t        ptr_sel_r;
	logic [15:0] ptr_new_r, dmem_addr_r, pmem_addr_r, pmem_wdata_r, sp_r;
	logic [7:0]  dmem_wdata_r;
	logic        dmem_we_r, dmem_re_r, pmem_re_r, pmem_we_r;

	// ==========================================
	// Decode of the accepted instruction
	wire         acc      = instr_valid && instr_ready;
	wire         is_store = instr_op inside {OP_STORE_IND, OP_STORE_POSTINC, OP_STORE_PREDEC,
		OP_STORE_DISP, OP_STORE_DIRECT, OP_PUSH};
	wire         is_load  = instr_op inside {OP_LOAD_DISP, OP_LOAD_DIRECT, OP_POP};
	wire         is_pmr   = instr_op inside {OP_PM_READ_LOW, OP_PM_READ, OP_PM_READ_INC};
	wire         uses_z   = is_pmr || instr_op inside {OP_LOAD_DISP, OP_PM_WRITE};
	wire         ptr_upd  = instr_op inside {OP_STORE_POSTINC, OP_STORE_PREDEC, OP_PM_READ_INC};
	wire [15:0]  ptr      = rf.pair_data;
	wire [15:0]  disp16   = 16'(instr_disp);
	wire [15:0]  ptr_inc  = ptr + `PTR_STEP;
	wire [15:0]  ptr_dec  = ptr - `PTR_STEP;
	wire [15:0]  sp_inc   = sp_r + `PTR_STEP;
	wire [15:0]  sp_dec   = sp_r - `PTR_STEP;
	wire [15:0]  ea;
	wire [4:0]   dest     = (instr_op == OP_PM_READ_LOW) ? `REG_LOW_WORD : instr_rd;

	assign ea = (instr_op inside {OP_LOAD_DISP, OP_STORE_DISP}) ? ptr + disp16 :
		(instr_op inside {OP_LOAD_DIRECT, OP_STORE_DIRECT}) ? instr_addr :
		(instr_op == OP_STORE_PREDEC) ? ptr_dec :
		(instr_op == OP_PUSH) ? sp_r :
		(instr_op == OP_POP) ? sp_inc : ptr;

	assign instr_ready = (state_r == SEQ_IDLE);
	assign rf.pair_sel = uses_z ? PTR_Z : instr_ptr;
	assign rf.rd_idx   = instr_rr;

	// ==========================================
	// Register write-back; flags have no write path at all
	wire in_wr  = acc && instr_op == OP_PORT_IN;
	wire mem_wr = state_r == SEQ_MEM && dmem_re_r;
	wire pm_wr  = state_r == SEQ_PM2;
	assign rf.wr_en   = in_wr || mem_wr || pm_wr;
	assign rf.wr_idx  = in_wr ? instr_rd : rd_r;
	assign rf.wr_data = in_wr ? io_rdata : mem_wr ? dmem_rdata : pmem_rdata;
	assign rf.pw_en   = ptr_upd_r && (state_r == SEQ_MEM || pm_wr);
	assign rf.pw_sel  = ptr_sel_r;
	assign rf.pw_data = ptr_new_r;

	// ==========================================
	// Port and control outputs act in the accepting cycle
	assign io_addr     = instr_port;
	assign io_wdata    = rf.rd_data;
	assign io_we       = acc && instr_op == OP_PORT_OUT;
	assign io_re       = in_wr;
	assign sleep_req   = acc && instr_op == OP_SLEEP;
	assign wdt_restart = acc && instr_op == OP_WATCHDOG;
	assign break_req   = acc && instr_op == OP_BREAK;

	assign dmem_addr  = dmem_addr_r;
	assign dmem_wdata = dmem_wdata_r;
	assign dmem_we    = dmem_we_r;
	assign dmem_re    = dmem_re_r;
	assign stack_ptr  = sp_r;
	assign pmem_addr  = pmem_addr_r;
	assign pmem_re    = pmem_re_r;
	assign pmem_we    = pmem_we_r;
	assign pmem_wdata = pmem_wdata_r;

	// ==========================================
	// Sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SEQ_IDLE: begin
				if (acc && (is_load || is_store)) state_nxt = SEQ_MEM;
				else if (acc && is_pmr) state_nxt = SEQ_PM1;
				else if (acc && instr_op == OP_PM_WRITE) state_nxt = SEQ_PMW;
				else if (acc && instr_op == OP_BREAK) state_nxt = SEQ_BRK;
			end
			SEQ_MEM: state_nxt = SEQ_IDLE;
			SEQ_PM1: state_nxt = SEQ_PM2;
			SEQ_PM2: state_nxt = SEQ_IDLE;
			SEQ_PMW: begin
				if (pmem_done) state_nxt = SEQ_IDLE;
			end
			SEQ_BRK: begin
				if (debug_resume) state_nxt = SEQ_IDLE;
			end
			default: state_nxt = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) state_r <= SEQ_IDLE;
		else state_r <= state_nxt;
	end

	// Operands latched at acceptance so the second cycle sees stable values
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_r         <= `REG_LOW_WORD;
			ptr_upd_r    <= 1'b0;
			ptr_sel_r    <= PTR_LOW;
			ptr_new_r    <= `WORD_RESET;
			dmem_addr_r  <= `WORD_RESET;
			dmem_wdata_r <= `BYTE_RESET;
		end else if (acc) begin
			rd_r         <= dest;
			ptr_upd_r    <= ptr_upd;
			ptr_sel_r    <= rf.pair_sel;
			ptr_new_r    <= (instr_op == OP_STORE_PREDEC) ? ptr_dec : ptr_inc;
			dmem_addr_r  <= ea;
			dmem_wdata_r <= rf.rd_data;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dmem_we_r <= 1'b0;
			dmem_re_r <= 1'b0;
			pmem_re_r <= 1'b0;
			sp_r      <= `SP_RESET;
		end else begin
			dmem_we_r <= acc && is_store;
			dmem_re_r <= acc && is_load;
			pmem_re_r <= acc && is_pmr;
			if (acc && instr_op == OP_PUSH) sp_r <= sp_dec;
			else if (acc && instr_op == OP_POP) sp_r <= sp_inc;
		end
	end

	// Program write strobe holds until the memory reports completion
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pmem_we_r    <= 1'b0;
			pmem_addr_r  <= `WORD_RESET;
			pmem_wdata_r <= `WORD_RESET;
		end else if (acc && (is_pmr || instr_op == OP_PM_WRITE)) begin
			pmem_we_r    <= instr_op == OP_PM_WRITE;
			pmem_addr_r  <= ptr;
			pmem_wdata_r <= rf.low_word;
		end else if (pmem_done) begin
			pmem_we_r    <= 1'b0;
		end
	end

	// ==========================================
	// Assertions
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence s_finish;
		instr_ready;
	endsequence
	sequence s_busy_done;
		!instr_ready ##1 s_finish;
	endsequence

	property p_load_disp;
		acc && instr_op == OP_LOAD_DISP |=> dmem_re && dmem_addr == $past(ptr + disp16)
			&& rf.wr_en && rf.wr_data == dmem_rdata ##1 s_finish;
	endproperty
	a_load_disp: assert property (p_load_disp) else $error("displacement load wrong");

	property p_load_direct;
		acc && instr_op == OP_LOAD_DIRECT |=> s_busy_done and (dmem_addr == $past(instr_addr));
	endproperty
	a_load_direct: assert property (p_load_direct) else $error("direct load wrong");

	property p_store_plain;
		acc && instr_op == OP_STORE_IND |-> ##1 dmem_we && dmem_addr == $past(ptr)
			&& dmem_wdata == $past(rf.rd_data) && !rf.pw_en ##1 s_finish;
	endproperty
	a_store_plain: assert property (p_store_plain) else $error("plain store wrong");

	property p_store_post;
		acc && instr_op == OP_STORE_POSTINC |=> dmem_we && dmem_addr == $past(ptr)
			&& rf.pw_en && rf.pw_data == dmem_addr + `PTR_STEP ##1 s_finish;
	endproperty
	a_store_post: assert property (p_store_post) else $error("post-increment store wrong");

	property p_store_pre;
		acc && instr_op == OP_STORE_PREDEC |=> dmem_we && dmem_addr == $past(ptr) - `PTR_STEP
			&& rf.pw_en && rf.pw_data == dmem_addr;
	endproperty
	a_store_pre: assert property (p_store_pre) else $error("pre-decrement store wrong");

	property p_store_disp;
		acc && instr_op == OP_STORE_DISP |=> dmem_we && !rf.pw_en
			&& dmem_addr == $past(ptr) + $past(disp16) ##1 s_finish;
	endproperty
	a_store_disp: assert property (p_store_disp) else $error("displacement store wrong");

	property p_store_direct;
		acc && instr_op == OP_STORE_DIRECT |=> dmem_we && dmem_addr == $past(instr_addr) ##1 s_finish;
	endproperty
	a_store_direct: assert property (p_store_direct) else $error("direct store wrong");

	property p_pm_read;
		acc && is_pmr |=> pmem_re && pmem_addr == $past(ptr) ##1 rf.wr_en && !instr_ready
			&& rf.wr_data == pmem_rdata ##1 s_finish;
	endproperty
	a_pm_read: assert property (p_pm_read) else $error("program read wrong");

	property p_pm_write;
		acc && instr_op == OP_PM_WRITE |=> pmem_we && pmem_wdata == $past(rf.low_word) && !instr_ready;
	endproperty
	a_pm_write: assert property (p_pm_write) else $error("program write wrong");

	property p_push;
		acc && instr_op == OP_PUSH |=> dmem_we && dmem_addr == $past(sp_r)
			&& stack_ptr == dmem_addr - `PTR_STEP ##1 s_finish;
	endproperty
	a_push: assert property (p_push) else $error("push wrong");

	property p_pop;
		acc && instr_op == OP_POP |=> dmem_re && dmem_addr == stack_ptr && rf.wr_en
			&& stack_ptr == $past(sp_r) + `PTR_STEP ##1 s_finish;
	endproperty
	a_pop: assert property (p_pop) else $error("pop wrong");

	property p_sleep;
		sleep_req |-> acc && !rf.wr_en ##1 s_finish;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not single cycle");

	// Back-to-back restarts are legal, so only the owning op and the free slot are checked
	property p_wdt_restart;
		wdt_restart |-> acc && instr_op == OP_WATCHDOG && !rf.wr_en ##1 s_finish;
	endproperty
	a_wdt_restart: assert property (p_wdt_restart) else $error("watchdog restart wrong");

	property p_break;
		break_req ##1 !debug_resume |=> !instr_ready;
	endproperty
	a_break: assert property (p_break) else $error("break released early");

	property p_port;
		acc && instr_op inside {OP_PORT_IN, OP_PORT_OUT} |-> (io_re || io_we)
			&& (!io_re || rf.wr_data == io_rdata) ##1 s_finish;
	endproperty
	a_port: assert property (p_port) else $error("port transfer wrong");

	property p_idle;
		acc && instr_op == OP_IDLE_INSTR |-> !rf.wr_en && !rf.pw_en ##1 (s_finish and !dmem_we);
	endproperty
	a_idle: assert property (p_idle) else $error("idle instruction had effect");
endmodule : xfer_ctrl_exec

// [testbench/mem_partner.sv]
// Behavioural data SRAM, stack and program memory facing the execution unit.
// Assumes one clock; data reads answer at once, program reads one cycle late.
module mem_partner (
	// Clock
	input  wire logic        clk_sys,
	// Data memory and stack
	input  wire logic [15:0] dmem_addr,
	input  wire logic [7:0]  dmem_wdata,
	input  wire logic        dmem_we,
	input  wire logic        dmem_re,
	output logic      [7:0]  dmem_rdata,
	// Program memory
	input  wire logic [15:0] pmem_addr,
	input  wire logic        pmem_re,
	output logic      [7:0]  pmem_rdata,
	input  wire logic        pmem_we,
	input  wire logic [15:0] pmem_wdata,
	output logic             pmem_done,
	// Program write raises done pm_delay + 1 cycles after its strobe rises
	input  wire logic [3:0]  pm_delay
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0]  dmem     [0:65535];
	logic [7:0]  pmem     [0:65535];
	logic [15:0] pm_word  [0:65535];
	logic [7:0]  dlast_r  = 8'h00;
	logic [7:0]  prd_r    = 8'h00;
	logic        pvalid_r = 1'b0;
	logic        done_r   = 1'b0;
	logic [3:0]  wcnt_r   = 4'h0;

	// =====================
	// Data memory
	// Idle bus shows the inverse of the last byte, so stale data never matches by luck
	assign dmem_rdata = (dmem_re === 1'b1) ? dmem[dmem_addr] : ~dlast_r;
	always @(posedge clk_sys) begin
		if (dmem_re === 1'b1) dlast_r <= dmem[dmem_addr];
		if (dmem_we === 1'b1) dmem[dmem_addr] <= dmem_wdata;
	end

	// =====================
	// Program memory
	assign pmem_rdata = pvalid_r ? prd_r : ~prd_r;
	assign pmem_done  = done_r;
	always @(posedge clk_sys) begin
		pvalid_r <= (pmem_re === 1'b1);
		if (pmem_re === 1'b1) prd_r <= pmem[pmem_addr];
		if (pmem_we === 1'b1 && !done_r) begin
			if (wcnt_r == pm_delay) begin
				done_r                <= 1'b1;
				pm_word[pmem_addr]    <= pmem_wdata;
				wcnt_r                <= 4'h0;
			end else begin
				wcnt_r <= wcnt_r + 4'h1;
			end
		end else begin
			done_r <= 1'b0;
			wcnt_r <= 4'h0;
		end
	end
endmodule : mem_partner

// [testbench/data_transfer_and_mcu_control_exec_bench.sv]
// Self-checking bench for the transfer and control execution unit.
// Assumes registers start at zero; they are loaded by port-in and read by port-out.
`include "exec_params.svh"
`define CHECK_EQ(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module data_transfer_and_mcu_control_exec_bench
	import exec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_sys, nrst, instr_valid, instr_ready, debug_resume;
	op_t         instr_op;
	ptr_t        instr_ptr;
	logic [4:0]  instr_rd, instr_rr;
	logic [5:0]  instr_disp, instr_port, io_addr, io_addr_log, in_addr_log;
	logic [15:0] instr_addr, dmem_addr, stack_ptr, pmem_addr, pmem_wdata;
	logic [7:0]  dmem_wdata, dmem_rdata, pmem_rdata, io_wdata, io_rdata, io_log;
	logic        dmem_we, dmem_re, pmem_re, pmem_we, pmem_done, io_we, io_re;
	logic        sleep_req, wdt_restart, break_req;
	logic [3:0]  pm_delay;
	int          err_count, n_tests, last_cyc, fast, ticks, sleep_cnt, wdt_cnt, brk_cnt;

	xfer_ctrl_exec dut_u (.clk_sys(clk_sys), .nrst(nrst), .instr_valid(instr_valid),
		.instr_ready(instr_ready), .instr_op(instr_op), .instr_rd(instr_rd), .instr_rr(instr_rr),
		.instr_ptr(instr_ptr), .instr_disp(instr_disp), .instr_addr(instr_addr), .instr_port(instr_port),
		.dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re),
		.dmem_rdata(dmem_rdata), .stack_ptr(stack_ptr), .pmem_addr(pmem_addr), .pmem_re(pmem_re),
		.pmem_rdata(pmem_rdata), .pmem_we(pmem_we), .pmem_wdata(pmem_wdata), .pmem_done(pmem_done),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
		.sleep_req(sleep_req), .wdt_restart(wdt_restart), .break_req(break_req),
		.debug_resume(debug_resume));
	mem_partner part_u (.clk_sys(clk_sys), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
		.dmem_we(dmem_we), .dmem_re(dmem_re), .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr),
		.pmem_re(pmem_re), .pmem_rdata(pmem_rdata), .pmem_we(pmem_we), .pmem_wdata(pmem_wdata),
		.pmem_done(pmem_done), .pm_delay(pm_delay));

	// =====================
	// Clock, monitors, hang guard
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (io_we === 1'b1) io_log <= io_wdata;
		if (io_we === 1'b1) io_addr_log <= io_addr;
		if (io_re === 1'b1) in_addr_log <= io_addr;
		if (sleep_req === 1'b1) sleep_cnt++;
		if (wdt_restart === 1'b1) wdt_cnt++;
		if (break_req === 1'b1) brk_cnt++;
		ticks++;
		if (ticks == 4000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	// =====================
	// Shared drivers
	// Valid stays up between calls so back-to-back ops never drop it in one time step
	task automatic run(input op_t op, input logic [4:0] rd = 5'h00, input logic [4:0] rr = 5'h00,
		input ptr_t p = PTR_X, input logic [5:0] q = 6'h00, input logic [15:0] k = 16'h0000,
		input logic [5:0] pa = 6'h2A);
		instr_valid = 1'b1;
		instr_op    = op;
		instr_rd    = rd;
		instr_rr    = rr;
		instr_ptr   = p;
		instr_disp  = q;
		instr_addr  = k;
		instr_port  = pa;
		@(posedge clk_sys);
		#1;
		last_cyc = 1;
		while (instr_ready !== 1'b1 && last_cyc < 40) begin
			@(posedge clk_sys);
			#1;
			last_cyc++;
		end
	endtask : run

	task automatic load_reg(input logic [4:0] idx, input logic [7:0] val);
		io_rdata = val;
		run(.op(OP_PORT_IN), .rd(idx), .pa({1'b1, idx}));
		`CHECK_EQ(last_cyc, 1)
		`CHECK_EQ(in_addr_log, {1'b1, idx})
	endtask : load_reg

	task automatic chk_reg(input logic [4:0] idx, input logic [7:0] exp);
		run(.op(OP_PORT_OUT), .rr(idx), .pa({1'b0, idx}));
		`CHECK_EQ(io_log, exp)
		`CHECK_EQ(io_addr_log, {1'b0, idx})
	endtask : chk_reg

	task automatic set_pair(input logic [4:0] base, input logic [15:0] val);
		load_reg(base, val[7:0]);
		load_reg(base + 5'h01, val[15:8]);
	endtask : set_pair

	task automatic chk_pair(input logic [4:0] base, input logic [15:0] exp);
		chk_reg(base, exp[7:0]);
		chk_reg(base + 5'h01, exp[15:8]);
	endtask : chk_pair

	// =====================
	// Scenarios
	task automatic s_port_idle();
		load_reg(5'h03, 8'h5A);
		load_reg(5'h04, 8'hA5);
		run(.op(OP_IDLE_INSTR));
		`CHECK_EQ(last_cyc, 1)
		chk_reg(5'h03, 8'h5A);
		`CHECK_EQ(io_addr_log, 6'h03)
	endtask : s_port_idle

	// Pointer carries and borrows cross the byte boundary on purpose
	task automatic s_stores();
		set_pair(`BASE_X, 16'h0100);
		run(.op(OP_STORE_IND), .rr(5'h03), .p(PTR_X));
		`CHECK_EQ(last_cyc, 2)
		`CHECK_EQ(part_u.dmem[16'h0100], 8'h5A)
		chk_pair(`BASE_X, 16'h0100);
		set_pair(`BASE_Y, 16'h00FF);
		run(.op(OP_STORE_POSTINC), .rr(5'h04), .p(PTR_Y));
		`CHECK_EQ(last_cyc, 2)
		`CHECK_EQ(part_u.dmem[16'h00FF], 8'hA5)
		chk_pair(`BASE_Y, 16'h0100);
		set_pair(`BASE_Z, 16'h0200);
		run(.op(OP_STORE_PREDEC), .rr(5'h03), .p(PTR_Z));
		`CHECK_EQ(last_cyc, 2)
		`CHECK_EQ(part_u.dmem[16'h01FF], 8'h5A)
		chk_pair(`BASE_Z, 16'h01FF);
		run(.op(OP_STORE_DISP), .rr(5'h04), .p(PTR_Y), .q(6'h3F));
		`CHECK_EQ(last_cyc, 2)
		`CHECK_EQ(part_u.dmem[16'h013F], 8'hA5)
		run(.op(OP_STORE_DISP), .rr(5'h03), .p(PTR_Z), .q(6'h01));
		`CHECK_EQ(part_u.dmem[16'h0200], 8'h5A)
		chk_pair(`BASE_Y, 16'h0100);
		run(.op(OP_STORE_DIRECT), .rr(5'h04), .k(16'h1234));
		`CHECK_EQ(last_cyc, 2)
		`CHECK_EQ(part_u.dmem[16'h1234], 8'hA5)
	endtask : s_stores

	task automatic s_loads();
		part_u.dmem[16'h023E] = 8'hC7;
		part_u.dmem[16'hFFFF] = 8'h96;
		run(.op(OP_LOAD_DISP), .rd(5'h0B), .q(6'h3F));
		`CHECK_EQ(last_cyc, 2)
		chk_reg(5'h0B, 8'hC7);
		run(.op(OP_LOAD_DIRECT), .rd(5'h0C), .k(16'hFFFF));
		`CHECK_EQ(last_cyc, 2)
		chk_reg(5'h0C, 8'h96);
	endtask : s_loads

	task automatic s_pm();
		part_u.pmem[16'h0400] = 8'h3C;
		part_u.pmem[16'h0401] = 8'hE1;
		set_pair(`BASE_Z, 16'h0400);
		run(.op(OP_PM_READ_LOW), .rd(5'h07));
		`CHECK_EQ(last_cyc, 3)
		chk_reg(`REG_LOW_WORD, 8'h3C);
		chk_reg(5'h07, 8'h00);
		run(.op(OP_PM_READ_INC), .rd(5'h09));
		chk_reg(5'h09, 8'h3C);
		run(.op(OP_PM_READ), .rd(5'h0A));
		`CHECK_EQ(last_cyc, 3)
		chk_reg(5'h0A, 8'hE1);
		chk_pair(`BASE_Z, 16'h0401);
		set_pair(`REG_LOW_WORD, 16'h1234);
		pm_delay = 4'h1;
		run(.op(OP_PM_WRITE));
		fast = last_cyc;
		`CHECK_EQ(part_u.pm_word[16'h0401], 16'h1234)
		set_pair(`REG_LOW_WORD, 16'hABCD);
		pm_delay = 4'h5;
		run(.op(OP_PM_WRITE));
		`CHECK_EQ(last_cyc - fast, 4)
		`CHECK_EQ(part_u.pm_word[16'h0401], 16'hABCD)
	endtask : s_pm

	task automatic s_stack();
		`CHECK_EQ(stack_ptr, 16'h00FF)
		run(.op(OP_PUSH), .rr(5'h03));
		`CHECK_EQ(last_cyc, 2)
		run(.op(OP_PUSH), .rr(5'h04));
		`CHECK_EQ(part_u.dmem[16'h00FF], 8'h5A)
		`CHECK_EQ(part_u.dmem[16'h00FE], 8'hA5)
		`CHECK_EQ(stack_ptr, 16'h00FD)
		run(.op(OP_POP), .rd(5'h0D));
		`CHECK_EQ(last_cyc, 2)
		run(.op(OP_POP), .rd(5'h0E));
		chk_reg(5'h0D, 8'hA5);
		chk_reg(5'h0E, 8'h5A);
		`CHECK_EQ(stack_ptr, 16'h00FF)
	endtask : s_stack

	task automatic s_control();
		run(.op(OP_SLEEP));
		`CHECK_EQ(last_cyc, 1)
		`CHECK_EQ(sleep_cnt, 1)
		run(.op(OP_WATCHDOG));
		`CHECK_EQ(last_cyc, 1)
		`CHECK_EQ(wdt_cnt, 1)
		fork
			run(.op(OP_BREAK));
			begin
				repeat (4) @(posedge clk_sys);
				#1 debug_resume = 1'b1;
				@(posedge clk_sys);
				#1 debug_resume = 1'b0;
			end
		join
		`CHECK_EQ(brk_cnt, 1)
		`CHECK_EQ(last_cyc, 5)
		chk_reg(5'h03, 8'h5A);
	endtask : s_control

	// =====================
	// Main sequence
	initial begin
		{nrst, instr_valid, debug_resume, err_count, n_tests, ticks} = '0;
		{sleep_cnt, wdt_cnt, brk_cnt, last_cyc, fast} = '0;
		{instr_rd, instr_rr, instr_disp, instr_addr, instr_port, io_rdata} = '0;
		instr_op = OP_IDLE_INSTR;
		instr_ptr = PTR_X;
		pm_delay = 4'h1;
		repeat (5) @(posedge clk_sys);
		#1 nrst = 1'b1;
		s_port_idle();
		s_stores();
		s_loads();
		s_pm();
		s_stack();
		s_control();
		instr_valid = 1'b0;
		wrap_up();
	end
endmodule : data_transfer_and_mcu_control_exec_bench
